// ---- rtl/t1e1_tx_pkg.sv ----
// Shared definitions of the T1/E1 transmit line coder: timing counts, register
// map and field layout, lookup tables and the carrier structs.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
package t1e1_tx_pkg;
	// Timing of the line pulse, taken from the system clock.
	localparam int SYS_CLK_MHZ = 50;
	localparam int PULSE_WIDTH_NS = 80;
	localparam int PULSE_CYC = (PULSE_WIDTH_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [2:0] PULSE_LAST = 3'(PULSE_CYC - 1);
	// Bit times without a pulse tolerated before the driver is declared failed.
	localparam logic [7:0] DMO_LIMIT = 8'h80;
	// Slots of the substitution patterns.
	localparam logic [2:0] SLOT_FIRST = 3'h0;
	localparam logic [2:0] SLOT_NEXT = 3'h1;
	localparam logic [2:0] SLOT_V1 = 3'h3;
	localparam logic [2:0] SLOT_B1 = 3'h4;
	localparam logic [2:0] SLOT_V2 = 3'h6;
	localparam logic [2:0] SLOT_B2 = 3'h7;
	localparam logic [2:0] HDB3_LAST = 3'h3;
	localparam logic [2:0] B8ZS_LAST = 3'h7;
	// Register byte offsets.
	localparam logic [4:0] ADDR_CTRL0 = 5'h00;
	localparam logic [4:0] ADDR_CTRL1 = 5'h04;
	localparam logic [4:0] ADDR_IRQ_EN = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0c;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
	// Field positions.
	localparam int C0_CODE = 5;
	localparam int C0_SRAIL = 6;
	localparam int C0_EDGE = 7;
	localparam int C1_RXRES = 2;
	localparam int C1_RX_TERM_INTERNAL_SEL = 7;
	localparam int ST_DMO = 0;
	localparam int ST_E1 = 1;
	localparam int ST_GAIN = 2;
	localparam int ST_ARB = 3;
	localparam int IRQ_DMO = 0;
	// Reset values.
	localparam logic [7:0] CTRL0_RST = 8'h48;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Equalizer and build-out code ranges of the T1 settings.
	localparam logic [4:0] EQ_T1_SH_FIRST = 5'h08;
	localparam logic [4:0] EQ_T1_SH_ARB = 5'h0d;
	localparam logic [4:0] EQ_T1_GM_FIRST = 5'h0e;
	localparam logic [4:0] EQ_T1_GM_ARB = 5'h13;
	// Internal receive resistor in ohms, indexed by {resistor code, impedance code}.
	localparam logic [9:0] RINT_OHMS [16] = '{10'h064, 10'h06e, 10'h04b, 10'h078,
		10'h0ac, 10'h0cc, 10'h06c, 10'h0f0, 10'h0c0, 10'h0e8, 10'h074, 10'h118,
		10'h12c, 10'h19c, 10'h096, 10'h258};
	// Assumed external resistor in ohms, indexed by resistor code; zero means none.
	localparam logic [9:0] REXT_OHMS [4] = '{10'h000, 10'h0f0, 10'h0d2, 10'h096};

	typedef enum logic [1:0] {SYM_SPACE, SYM_B, SYM_V} sym_t;

	// Static strap and control pins used in hardware control.
	typedef struct packed {
		logic host_mode;
		logic single_rail;
		logic edge_sel;
		logic rx_term_internal_sel;
		logic [1:0] term_impedance_sel;
		logic [1:0] rx_ext_resistor_sel;
		logic [4:0] equalizer_buildout_code;
	} hw_pins_t;

	// Decoded operating mode and pulse shape.
	typedef struct packed {
		logic valid;
		logic e1;
		logic gain;
		logic arb;
		logic cable_120;
		logic [2:0] line_build_out;
	} mode_t;
endpackage

// ---- rtl/t1e1_tx_line_coder.sv ----
// Transmit line coder with driver failure monitor, equalizer code decode and
// receive termination select, with an AXI4-Lite register slave.
// Assumes the transmit clock and all pins are asynchronous to i_sys_clk and
// that the transmit clock runs well below a quarter of the system clock.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps

module t1e1_tx_line_coder (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [4:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [4:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_tx_clock_in,
	input wire logic i_pos_rail_tx_data_in,
	input wire logic i_neg_rail_or_code_select_pin,
	input wire t1e1_tx_pkg::hw_pins_t i_hw_pins,
	output logic o_tx_line_out_a,
	output logic o_tx_line_out_b,
	output logic o_driver_fail_flag,
	output logic o_driver_fail_irq,
	output t1e1_tx_pkg::mode_t o_mode,
	output logic o_rx_term_internal,
	output logic [9:0] o_rx_term_int_ohms,
	output logic [9:0] o_rx_ext_ohms
);
	import t1e1_tx_pkg::*;

	hw_pins_t pins_s1_q, pins_s2_q;
	logic [2:0] line_s1_q, line_s2_q;
	logic clk_s3_q;
	logic [7:0] ctrl0_q, ctrl1_q;
	logic irq_en_q, irq_stat_q, dmo_prev_q;
	logic aw_full_q, w_full_q;
	logic [4:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_strb_q;
	logic [7:0] sr_q;
	logic sub_q, kind_q, even_q, last_pol_q, par_q;
	logic [2:0] idx_q, pcnt_q;
	logic [7:0] dmo_cnt_q;
	logic host, single, code_ami, edge_sel, ev, start, hdb_now, zero_run, mark, pol;
	logic [4:0] eqc;
	logic [32:0] wr_lookup, rd_lookup;
	sym_t sym;
	mode_t mode;

	// Decodes the five-bit equalizer and build-out code.
	function automatic mode_t eq_decode(input logic [4:0] c);
		mode_t m;
		m = '0;
		m.e1 = c[4] & c[3];
		if (m.e1) begin
			m.valid = c[2];
			m.gain = c[1];
			m.cable_120 = c[0];
		end else if (c >= EQ_T1_SH_FIRST && c <= EQ_T1_SH_ARB) begin
			m.valid = 1'b1;
			m.arb = (c == EQ_T1_SH_ARB);
			m.line_build_out = 3'(c - EQ_T1_SH_FIRST);
		end else if (c >= EQ_T1_GM_FIRST && c <= EQ_T1_GM_ARB) begin
			m.valid = 1'b1;
			m.gain = 1'b1;
			m.arb = (c == EQ_T1_GM_ARB);
			m.line_build_out = 3'(c - EQ_T1_GM_FIRST);
		end
		return m;
	endfunction

	// Symbol of a substitution pattern at a given slot.
	function automatic sym_t sub_sym(input logic is_hdb, input logic even, input logic [2:0] k);
		if (is_hdb) begin
			if (k == SLOT_V1)
				return SYM_V;
			return (k == SLOT_FIRST && even) ? SYM_B : SYM_SPACE;
		end
		if (k == SLOT_V1 || k == SLOT_V2)
			return SYM_V;
		return (k == SLOT_B1 || k == SLOT_B2) ? SYM_B : SYM_SPACE;
	endfunction

	// Register word that a read at the given offset returns.
	function automatic logic [32:0] rd_word(input logic [4:0] a);
		case (a)
			ADDR_CTRL0: rd_word = {1'b1, 24'h0, ctrl0_q};
			ADDR_CTRL1: rd_word = {1'b1, 24'h0, ctrl1_q};
			ADDR_IRQ_EN: rd_word = {1'b1, 31'h0, irq_en_q};
			ADDR_STATUS: rd_word = {1'b1, 28'h0, o_mode.arb, o_mode.gain, o_mode.e1, o_driver_fail_flag};
			ADDR_IRQ_STAT: rd_word = {1'b1, 31'h0, irq_stat_q};
			default: rd_word = {1'b0, 32'h0};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for every pin; the clock gets a third stage for edges.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			pins_s1_q <= '0;
			pins_s2_q <= '0;
			line_s1_q <= 3'h0;
			line_s2_q <= 3'h0;
			clk_s3_q <= 1'b0;
		end else begin
			pins_s1_q <= i_hw_pins;
			pins_s2_q <= pins_s1_q;
			line_s1_q <= {i_tx_clock_in, i_pos_rail_tx_data_in, i_neg_rail_or_code_select_pin};
			line_s2_q <= line_s1_q;
			clk_s3_q <= line_s2_q[2];
		end
	end

	// Effective configuration: host registers or hardware pins.
	assign host = pins_s2_q.host_mode;
	assign single = host ? ctrl0_q[C0_SRAIL] : pins_s2_q.single_rail;
	assign code_ami = host ? ctrl0_q[C0_CODE] : line_s2_q[0];
	assign edge_sel = host ? ctrl0_q[C0_EDGE] : pins_s2_q.edge_sel;
	assign eqc = host ? ctrl0_q[4:0] : pins_s2_q.equalizer_buildout_code;
	assign mode = eq_decode(eqc);
	assign hdb_now = mode.e1;

	// Bit event on the selected transmit clock edge.
	assign ev = edge_sel ? (line_s2_q[2] & ~clk_s3_q) : (~line_s2_q[2] & clk_s3_q);

	////////////////////////////////////////////////////////////////////////////////
	// Symbol choice for the bit leaving the eight-bit look-ahead line.
	assign zero_run = hdb_now ? (sr_q[7:4] == 4'h0) : (sr_q == 8'h00);
	assign start = single && !code_ami && !sub_q && zero_run;
	always_comb begin
		sym = SYM_SPACE;
		mark = 1'b0;
		pol = 1'b0;
		if (!single) begin
			mark = line_s2_q[1] | line_s2_q[0];
			pol = line_s2_q[1];
		end else begin
			if (start)
				sym = sub_sym(hdb_now, ~par_q, SLOT_FIRST);
			else if (sub_q)
				sym = sub_sym(kind_q, even_q, idx_q);
			else
				sym = sr_q[7] ? SYM_B : SYM_SPACE;
			mark = (sym != SYM_SPACE);
			pol = (sym == SYM_V) ? last_pol_q : ~last_pol_q;
		end
	end

	// Look-ahead line and substitution sequencer.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			sr_q <= 8'hff;
			sub_q <= 1'b0;
			idx_q <= SLOT_FIRST;
			kind_q <= 1'b0;
			even_q <= 1'b0;
		end else begin
			if (ev)
				sr_q <= {sr_q[6:0], line_s2_q[1]};
			if (!single) begin
				sub_q <= 1'b0;
			end else if (ev && start) begin
				sub_q <= 1'b1;
				idx_q <= SLOT_NEXT;
				kind_q <= hdb_now;
				even_q <= ~par_q;
			end else if (ev && sub_q) begin
				idx_q <= idx_q + 3'h1;
				if (idx_q == (kind_q ? HDB3_LAST : B8ZS_LAST))
					sub_q <= 1'b0;
			end
		end
	end

	// Polarity of the last mark and parity of marks since the last violation.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			last_pol_q <= 1'b0;
			par_q <= 1'b0;
		end else if (ev && mark && single) begin
			last_pol_q <= pol;
			par_q <= (sym == SYM_V) ? 1'b0 : ~par_q;
		end
	end

	// Pulse shaper: fixed width counted on the system clock.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_tx_line_out_a <= 1'b0;
			o_tx_line_out_b <= 1'b0;
			pcnt_q <= 3'h0;
		end else if (ev && mark) begin
			o_tx_line_out_a <= pol;
			o_tx_line_out_b <= ~pol;
			pcnt_q <= PULSE_LAST;
		end else if (pcnt_q != 3'h0) begin
			pcnt_q <= pcnt_q - 3'h1;
		end else begin
			o_tx_line_out_a <= 1'b0;
			o_tx_line_out_b <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Driver failure monitor over the bit times of the line output.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			dmo_cnt_q <= 8'h00;
			o_driver_fail_flag <= 1'b0;
		end else if (ev && mark) begin
			dmo_cnt_q <= 8'h00;
			o_driver_fail_flag <= 1'b0;
		end else if (ev) begin
			if (dmo_cnt_q == DMO_LIMIT)
				o_driver_fail_flag <= 1'b1;
			else
				dmo_cnt_q <= dmo_cnt_q + 8'h01;
		end
	end

	// Interrupt in host mode on any change of the failure flag; a new event beats the clear.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			dmo_prev_q <= 1'b0;
			irq_stat_q <= 1'b0;
		end else begin
			dmo_prev_q <= o_driver_fail_flag;
			if (host && irq_en_q && (dmo_prev_q != o_driver_fail_flag))
				irq_stat_q <= 1'b1;
			else if (aw_full_q && w_full_q && !o_bvalid && aw_addr_q == ADDR_IRQ_STAT && w_strb_q
				&& w_data_q[IRQ_DMO])
				irq_stat_q <= 1'b0;
		end
	end
	assign o_driver_fail_irq = irq_stat_q;

	// Mode and termination outputs.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_mode <= '0;
			o_rx_term_internal <= 1'b0;
			o_rx_term_int_ohms <= 10'h000;
			o_rx_ext_ohms <= 10'h000;
		end else begin
			o_mode <= mode;
			if (host ? ctrl1_q[C1_RX_TERM_INTERNAL_SEL] : pins_s2_q.rx_term_internal_sel) begin
				o_rx_term_internal <= 1'b1;
				o_rx_term_int_ohms <= host ? RINT_OHMS[ctrl1_q[3:0]]
					: RINT_OHMS[{pins_s2_q.rx_ext_resistor_sel, pins_s2_q.term_impedance_sel}];
				o_rx_ext_ohms <= host ? REXT_OHMS[ctrl1_q[C1_RXRES +: 2]]
					: REXT_OHMS[pins_s2_q.rx_ext_resistor_sel];
			end else begin
				o_rx_term_internal <= 1'b0;
				o_rx_term_int_ohms <= 10'h000;
				o_rx_ext_ohms <= 10'h000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write: address and data held apart, committed together.
	assign o_awready = ~aw_full_q;
	assign o_wready = ~w_full_q;
	// Decode of the held write address and of the offered read address; bit 32 marks a mapped offset.
	assign wr_lookup = rd_word(aw_addr_q);
	assign rd_lookup = rd_word(i_araddr);
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 5'h00;
			w_data_q <= 8'h00;
			w_strb_q <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end else begin
			if (i_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= i_awaddr;
			end
			if (i_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= i_wdata[7:0];
				w_strb_q <= i_wstrb[0];
			end
			if (aw_full_q && w_full_q && !o_bvalid) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= wr_lookup[32] ? RESP_OKAY : RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Control registers written by software.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			ctrl0_q <= CTRL0_RST;
			ctrl1_q <= CTRL1_RST;
			irq_en_q <= 1'b0;
		end else if (aw_full_q && w_full_q && !o_bvalid && w_strb_q) begin
			case (aw_addr_q)
				ADDR_CTRL0: ctrl0_q <= w_data_q;
				ADDR_CTRL1: ctrl1_q <= w_data_q;
				ADDR_IRQ_EN: irq_en_q <= w_data_q[IRQ_DMO];
				default: ;
			endcase
		end
	end

	// AXI4-Lite read channel.
	assign o_arready = ~o_rvalid;
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= RESP_OKAY;
		end else if (i_arvalid && !o_rvalid) begin
			o_rvalid <= 1'b1;
			o_rdata <= rd_lookup[31:0];
			o_rresp <= rd_lookup[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the coder, monitor and decode.
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	property p_dual_no_sub;
		!single |=> !sub_q;
	endproperty
	a_dual_no_sub: assert property (p_dual_no_sub) else $error("substitution in dual rail");

	property p_hdb_end;
		ev && sub_q && kind_q && idx_q == HDB3_LAST |=> !sub_q && last_pol_q == $past(last_pol_q);
	endproperty
	a_hdb_end: assert property (p_hdb_end) else $error("HDB3 violation wrong");

	property p_hdb_first;
		ev && start && hdb_now |-> sym == (par_q ? SYM_SPACE : SYM_B);
	endproperty
	a_hdb_first: assert property (p_hdb_first) else $error("HDB3 parity choice wrong");

	property p_b8zs_v2;
		ev && sub_q && !kind_q && idx_q == SLOT_V2 |-> sym == SYM_V;
	endproperty
	a_b8zs_v2: assert property (p_b8zs_v2) else $error("B8ZS second violation missing");

	property p_b8zs_b1;
		ev && sub_q && !kind_q && idx_q == SLOT_B1 |=> last_pol_q != $past(last_pol_q);
	endproperty
	a_b8zs_b1: assert property (p_b8zs_b1) else $error("B8ZS bipolar polarity wrong");

	property p_dmo_set;
		ev && !mark && dmo_cnt_q == DMO_LIMIT |=> o_driver_fail_flag;
	endproperty
	a_dmo_set: assert property (p_dmo_set) else $error("driver fail not raised");

	property p_dmo_clr;
		ev && mark |=> !o_driver_fail_flag ##1 (dmo_cnt_q <= 8'h01);
	endproperty
	a_dmo_clr: assert property (p_dmo_clr) else $error("driver fail not cleared");

	property p_irq;
		host && irq_en_q && $changed(o_driver_fail_flag) |=> ##1 o_driver_fail_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("flag change gave no interrupt");

	property p_e1;
		1'b1 |=> o_mode.e1 == $past(eqc[4] & eqc[3]);
	endproperty
	a_e1: assert property (p_e1) else $error("E1 mode decode wrong");

	property p_pulse;
		$rose(o_tx_line_out_a) |-> o_tx_line_out_a[*4] ##1 !o_tx_line_out_a;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse width wrong");

	property p_term_reset;
		!$past(i_nrst) |-> !o_rx_term_internal;
	endproperty
	a_term_reset: assert property (p_term_reset) else $error("termination not external at reset");

	property p_edge;
		ev |-> (edge_sel ? line_s2_q[2] : !line_s2_q[2]);
	endproperty
	a_edge: assert property (p_edge) else $error("wrong sampling edge");

	property p_ami;
		ev && single && !sub_q && !start && sym == SYM_B |=> last_pol_q != $past(last_pol_q);
	endproperty
	a_ami: assert property (p_ami) else $error("AMI marks not alternating");

	property p_cov_hdb;
		ev && start && hdb_now;
	endproperty
	c_cov_hdb: cover property (p_cov_hdb);

	property p_cov_b8zs;
		ev && start && !hdb_now;
	endproperty
	c_cov_b8zs: cover property (p_cov_b8zs);

	property p_cov_irq;
		$rose(o_driver_fail_flag) ##[1:4] o_driver_fail_irq;
	endproperty
	c_cov_irq: cover property (p_cov_irq);
endmodule // t1e1_tx_line_coder

// ---- tb/t1e1_framer_model.sv ----
// Framer model: drives the transmit clock and single-rail NRZ data.
// Assumes the coder samples both pins on its own system clock.
`timescale 1ns/10ps

module t1e1_framer_model (
	input wire logic i_rise,
	output logic o_tx_clock,
	output logic o_tx_data
);
	typedef bit bits_t[$];

	// The clock stands still low between frames.
	initial begin
		o_tx_clock = 1'b0;
		o_tx_data = 1'b0;
	end

	// Sends a frame; data changes on the non-sampling edge, 80 ns from the sampling one.
	task automatic send(input bits_t q);
		// Step off the system clock edge so no pin moves in the sampling time step.
		#5;
		foreach (q[i]) begin
			o_tx_data = q[i];
			if (!i_rise) o_tx_clock = 1'b1;
			#80 o_tx_clock = ~o_tx_clock;
			#80 if (i_rise) o_tx_clock = 1'b0;
		end
		o_tx_data = ~o_tx_data; // Released data shows the inverse of the last bit.
	endtask
endmodule // t1e1_framer_model

// ---- tb/test_t1e1_tx_line_coder.sv ----
// Self-checking bench of the transmit line coder with its register slave.
// Assumes the package and the framer model are compiled first.
`timescale 1ns/10ps

module test_t1e1_tx_line_coder;
	import t1e1_tx_pkg::*;
	typedef bit bits_t[$];
	localparam logic [31:0] PAT = 32'ha200c201;
	localparam logic [7:0] MODES [5] = '{8'h48, 8'h5c, 8'h68, 8'h7c, 8'hc8};
	localparam int KINDS [5] = '{1, 2, 0, 0, 1};
	localparam logic [9:0] RINT [16] = '{10'h064, 10'h06e, 10'h04b, 10'h078, 10'h0ac, 10'h0cc, 10'h06c,
		10'h0f0, 10'h0c0, 10'h0e8, 10'h074, 10'h118, 10'h12c, 10'h19c, 10'h096, 10'h258};
	localparam logic [9:0] REXT [4] = '{10'h000, 10'h0f0, 10'h0d2, 10'h096};
	logic clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, rng = 32'h000078d7;
	logic [3:0] wstrb = 4'h0;
	logic neg_pin = 1'b0, edge_rise = 1'b0, pa = 1'b0, pb = 1'b0;
	hw_pins_t hw = '{host_mode: 1'b1, single_rail: 1'b1, default: '0};
	logic awready, wready, bvalid, arready, rvalid, line_a, line_b, fail, irq, term_int, tx_clock_in, tdata;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [9:0] int_ohms, ext_ohms;
	mode_t mode;
	int fails = 0, samples_checked = 0;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [1:0] lq[$];
	bit last_pol = 1'b0, par = 1'b0;

	always #10 clk = ~clk;

	t1e1_framer_model fr (.i_rise(edge_rise), .o_tx_clock(tx_clock_in), .o_tx_data(tdata));

	t1e1_tx_line_coder dut (.i_sys_clk(clk), .i_nrst(nrst), .i_awvalid(awvalid), .o_awready(awready),
		.i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
		.o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
		.i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
		.i_tx_clock_in(tx_clock_in), .i_pos_rail_tx_data_in(tdata), .i_neg_rail_or_code_select_pin(neg_pin),
		.i_hw_pins(hw), .o_tx_line_out_a(line_a), .o_tx_line_out_b(line_b), .o_driver_fail_flag(fail),
		.o_driver_fail_irq(irq), .o_mode(mode), .o_rx_term_internal(term_int),
		.o_rx_term_int_ohms(int_ohms), .o_rx_ext_ohms(ext_ohms));

	////////////////////////////////////////////////////////////////////////////
	// Compares one value and counts it.
	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		chk("pending marks", 34'(lq.size()), 34'h0);
		$display("checked %0d mismatched %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Xorshift source of stimulus.
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	function automatic bits_t fill(input bit v, input int n);
		bits_t q;
		repeat (n) q.push_back(v);
		return q;
	endfunction

	// AXI write: address and data offered together, each released when taken.
	task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
		bit aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		bq.push_back(r);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			aw_ok |= awready;
			w_ok |= wready;
			awvalid <= !aw_ok;
			wvalid <= !w_ok;
		end while (!(aw_ok && w_ok));
		while (!bvalid) @(posedge clk);
		bready <= 1'b0;
	endtask

	// AXI read; the expected response and data are noted for the monitor.
	task automatic axr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic mark(input bit p);
		lq.push_back({1'b1, p});
		last_pol = p;
	endtask

	// Notes the marks expected for a bit stream; m is 0 AMI, 1 B8ZS, 2 HDB3, 3 dual rail.
	task automatic expect_line(input bits_t b, input int m);
		int i, z;
		i = 0;
		while (i < b.size()) begin
			z = 0;
			while (i + z < b.size() && b[i + z] == 1'b0) z++;
			if (m == 1 && z >= 8) begin
				mark(last_pol);
				mark(!last_pol);
				mark(last_pol);
				mark(!last_pol);
				par = 1'b1;
				i += 8;
			end else if (m == 2 && z >= 4) begin
				if (!par) mark(!last_pol);
				mark(last_pol);
				par = 1'b0;
				i += 4;
			end else begin
				if (m == 3) begin
					if (b[i] || neg_pin) lq.push_back({1'b1, b[i]});
				end else if (b[i]) begin
					mark(!last_pol);
					par = !par;
				end
				i++;
			end
		end
	endtask

	// Sets the mode, then sends the data followed by ones that flush the delay line.
	task automatic run_line(input bits_t d, input logic [7:0] c0, input int m);
		bits_t s;
		axw(ADDR_CTRL0, c0, RESP_OKAY);
		edge_rise = c0[C0_EDGE];
		s = d;
		repeat (8) d.push_back(1'b1);
		if (m == 3) expect_line(d, 3);
		else begin
			repeat (8) s.push_front(1'b1);
			expect_line(s, m);
		end
		fr.send(d);
		repeat (12) @(posedge clk);
	endtask

	// Walks every equalizer code through the host register.
	task automatic eqc_scan();
		logic [4:0] q;
		logic sh, gm, ev;
		for (int c = 0; c < 32; c++) begin
			q = 5'(c);
			sh = q >= 5'h08 && q <= 5'h0d;
			gm = q >= 5'h0e && q <= 5'h13;
			ev = q >= 5'h1c;
			axw(ADDR_CTRL0, {3'b011, q}, RESP_OKAY);
			if (sh || gm || ev) axr(ADDR_STATUS, {28'h0, q == 5'h0d || q == 5'h13, gm || (ev && q[1]), ev, 1'b0}, RESP_OKAY);
			else axr(ADDR_CTRL0, {24'h0, 3'b011, q}, RESP_OKAY);
			chk("e1 mode", mode.e1, q[4] & q[3]);
			chk("code valid", mode.valid, sh || gm || ev);
			if (sh || gm) chk("build out", mode.line_build_out, sh ? q - 5'h08 : q - 5'h0e);
			if (ev) chk("cable", mode.cable_120, q[0]);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Monitor: takes the oldest note whenever a response or a mark appears.
	always @(posedge clk) begin
		pa <= line_a;
		pb <= line_b;
		if (rvalid && rready) chk("read", {rresp, rdata}, rq.pop_front());
		if (bvalid && bready) chk("write response", bresp, bq.pop_front());
		if (line_a && !pa) chk("positive mark", 2'b11, lq.pop_front());
		if (line_b && !pb) chk("negative mark", 2'b10, lq.pop_front());
	end

	// Watchdog cuts a hang short.
	initial begin
		#1000000;
		fails++;
		report_and_stop();
	end

	// Main sequence.
	initial begin
		bits_t d;
		logic [31:0] v;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		axr(ADDR_CTRL0, 32'h48, RESP_OKAY);
		axr(ADDR_CTRL1, 32'h0, RESP_OKAY);
		axr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
		axr(5'h14, 32'h0, RESP_SLVERR);
		axw(5'h14, 8'hff, RESP_SLVERR);
		axw(ADDR_STATUS, 8'hff, RESP_OKAY);
		axr(ADDR_STATUS, 32'h0, RESP_OKAY);
		chk("term after reset", term_int, 1'b0);
		eqc_scan();
		for (int k = 0; k < 5; k++) begin
			d = {};
			for (int i = 0; i < 32; i++) d.push_back(PAT[i]);
			repeat (24) begin
				v = xs();
				d.push_back(v[1:0] == 2'b00);
			end
			run_line(d, MODES[k], KINDS[k]);
		end
		// Driver failure: 128 spaces keep the flag low, the 129th raises it.
		axw(ADDR_IRQ_EN, 8'h01, RESP_OKAY);
		axw(ADDR_CTRL0, 8'h68, RESP_OKAY);
		edge_rise = 1'b0;
		expect_line({fill(1'b1, 8), fill(1'b0, 137), fill(1'b1, 8)}, 0);
		fr.send(fill(1'b0, 136));
		repeat (6) @(posedge clk);
		chk("fail flag low", fail, 1'b0);
		fr.send(fill(1'b0, 1));
		repeat (6) @(posedge clk);
		chk("fail flag high", fail, 1'b1);
		chk("fail irq", irq, 1'b1);
		axr(ADDR_STATUS, 32'h1, RESP_OKAY);
		axw(ADDR_IRQ_STAT, 8'h01, RESP_OKAY);
		axr(ADDR_IRQ_STAT, 32'h0, RESP_OKAY);
		fr.send(fill(1'b1, 8));
		fr.send(fill(1'b1, 8));
		repeat (6) @(posedge clk);
		chk("fail flag cleared", fail, 1'b0);
		axr(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
		// Hardware control: random straps for termination and equalizer code.
		repeat (8) begin
			v = xs();
			@(posedge clk);
			hw <= {3'b010, v[9:0]};
			repeat (6) @(posedge clk);
			chk("term pin", term_int, v[9]);
			chk("internal ohms", int_ohms, v[9] ? RINT[{v[6:5], v[8:7]}] : 10'h000);
			chk("external ohms", ext_ohms, v[9] ? REXT[v[6:5]] : 10'h000);
			chk("e1 pins", mode.e1, v[4] & v[3]);
		end
		@(posedge clk);
		hw <= {3'b110, 10'h000};
		axw(ADDR_CTRL1, 8'h8d, RESP_OKAY);
		axr(ADDR_CTRL1, 32'h8d, RESP_OKAY);
		chk("term host", term_int, 1'b1);
		chk("host ohms", int_ohms, 10'h19c);
		chk("host ext ohms", ext_ohms, 10'h096);
		run_line(fill(1'b1, 4), 8'h08, 3);
		@(posedge clk);
		neg_pin <= 1'b1;
		run_line({fill(1'b0, 4), fill(1'b1, 2)}, 8'h08, 3);
		report_and_stop();
	end
endmodule // test_t1e1_tx_line_coder
